//--- src/shrp_pkg.sv
// Shared constants and helpers for the serial host register port
package shrp_pkg;
  // Clock and link timing
  localparam int CLK_MHZ = 125;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCLK_PERIOD_NS = 80;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int WRITE_LATENCY_US = 250;
  localparam int WRITE_LATENCY_CYC = WRITE_LATENCY_US * CLK_MHZ;
  localparam int PROG_BUSY_CYC = 16;

  // Frame geometry
  localparam int ADDR_BITS = 8;
  localparam int BYTE_BITS = 8;
  localparam int WORD_BITS = 16;
  localparam int FRAME_BITS = ADDR_BITS + WORD_BITS;

  // Register addresses
  localparam logic [7:0] ADDR_RESET = 8'h01;
  localparam logic [7:0] ADDR_POWER = 8'hc0;
  localparam logic [7:0] ADDR_MODE = 8'hc1;
  localparam logic [7:0] ADDR_AUDIO = 8'hc2;
  localparam logic [7:0] ADDR_STATUS = 8'hc6;
  localparam logic [7:0] ADDR_PROG = 8'hc8;
  localparam logic [7:0] ADDR_SCRAMBLE = 8'hcb;
  localparam logic [7:0] ADDR_TONE = 8'hcd;
  localparam logic [7:0] ADDR_MASK = 8'hce;

  // Field layouts and reset values
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_EVT_LSB = 1;
  localparam logic [1:0] MODE_CODE_RX = 2'h1;
  localparam logic [1:0] MODE_CODE_TX = 2'h2;
  localparam logic [15:0] POWER_RESET = 16'h0000;

  typedef enum logic [1:0] {
    SHRP_IDLE = 2'b00,
    SHRP_RX = 2'b01,
    SHRP_TX = 2'b11
  } shrp_mode_e;

  // Data bytes that follow a given address byte
  function automatic logic [1:0] shrpDataBytes(input logic [7:0] a);
    logic [1:0] n;
    n = 2'h1;
    unique case (a)
      ADDR_RESET: n = 2'h0;
      ADDR_POWER, ADDR_MODE, ADDR_AUDIO, ADDR_STATUS, ADDR_PROG, ADDR_SCRAMBLE, ADDR_TONE,
      ADDR_MASK: n = 2'h2;
      default: n = 2'h1;
    endcase
    return n;
  endfunction

  // Read-only registers return data, all others except ADDR_RESET take it
  function automatic logic shrpIsRead(input logic [7:0] a);
    return a == ADDR_STATUS;
  endfunction

  // Total clocked bits of a frame
  function automatic logic [4:0] shrpFrameBits(input logic [7:0] a);
    return 5'(ADDR_BITS + BYTE_BITS * int'(shrpDataBytes(a)));
  endfunction
endpackage

//--- src/shrp_if.sv
`timescale 1ns/1ps
// Four-wire serial link plus open-drain interrupt
interface shrp_if;
  logic sclk;
  logic bus_select_n;
  logic cmdData;
  logic cmdOe;
  logic replyData;
  logic replyOe;
  logic irqOut;
  logic irqOe;
  logic irqN;

  // Open-drain interrupt line level, pulled high when nobody drives it
  assign irqN = !(irqOe && !irqOut);

  modport device (
    input sclk,
    input bus_select_n,
    input cmdData,
    output replyData,
    output replyOe,
    output irqOut,
    output irqOe
  );

  modport host (
    output sclk,
    output bus_select_n,
    output cmdData,
    output cmdOe,
    input replyData,
    input irqN
  );
endinterface

//--- src/shrp_device.sv
`timescale 1ns/1ps
// How it works
// (RULE1) Each frame: one address byte, then data
// (RULE2) Registers are write-only or read-only
// (RULE3) Command bits sampled on serial clock rise
// (RULE4) Reply bit valid while serial clock high
// (RULE5) Host holds select low per frame
// (RULE6) Address value fixes data byte count
// (RULE7) Bits travel most significant first
// (RULE8) Writes act within 250 us
// (RULE9) Address-only frame; 01 resets device
// (RULE10) One-byte registers take eight data bits
// (RULE11) Command and reply lines never both driven
// (RULE12) Serial clock may idle high or low
// (RULE13) Byte gaps optional, any length
// (RULE14) Interrupt only for unmasked status events
// (RULE15) Always exactly idle, receive or transmit
// (RULE16) Reset and power-on enter idle
// (RULE17) Programming writes accepted only in idle
// (RULE18) Host powers up, configures, then selects mode
// (RULE19) Host checks program-ready before programming
// (RULE20) Select release aborts frame, frees reply
module shrp_device #(
  parameter int EVT_W = 15,
  parameter int PROG_BUSY = shrp_pkg::PROG_BUSY_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  shrp_if.device link,
  output logic [1:0] mode,
  output logic [15:0] powerDown,
  output logic progWrStb,
  output logic [15:0] progData,
  output logic regWrStb,
  output logic [7:0] regWrAddr,
  output logic [15:0] regWrData,
  input wire logic [EVT_W-1:0] statusEvents
);
  // Elaboration check of parameters
  if (EVT_W < 1 || EVT_W > shrp_pkg::WORD_BITS - 1) begin : gBadEvt
    $error("EVT_W must be 1 to 15");
  end
  if (PROG_BUSY < 1 || PROG_BUSY > 255) begin : gBadBusy
    $error("PROG_BUSY must be 1 to 255");
  end

  localparam logic [7:0] PROG_BUSY_LD = 8'(PROG_BUSY);

  // Link-side frame state, cleared whenever select is high
  typedef struct packed {
    logic [4:0] bitCnt;
    logic [7:0] addr;
    logic [15:0] inShift;
    logic [15:0] outShift;
    logic done;
  } shrp_link_s;

  // Link-side hand-over words, kept across frames
  typedef struct packed {
    logic wrTog;
    logic rdTog;
    logic [7:0] wrAddr;
    logic [15:0] wrData;
  } shrp_post_s;

  // Core state on clk
  typedef struct packed {
    logic [2:0] wrSync;
    logic [2:0] rdSync;
    logic [2:0] selSync;
    logic wrAcc;
    logic rdAcc;
    shrp_pkg::shrp_mode_e mode;
    logic [15:0] powerDown;
    logic [EVT_W-1:0] irqMask;
    logic [EVT_W-1:0] sticky;
    logic [7:0] progTimer;
    logic [15:0] statusHold;
    logic irqPend;
    logic progWrStb;
    logic [15:0] progData;
    logic regWrStb;
    logic [7:0] regWrAddr;
    logic [15:0] regWrData;
  } shrp_core_s;

  shrp_link_s l;
  shrp_link_s next_l;
  shrp_post_s p;
  shrp_post_s next_p;
  shrp_core_s c;
  shrp_core_s next_c;
  logic linkRstN;
  logic replyBit;
  logic replyEn;
  logic [7:0] addrFull;
  logic readPhase;

  // Frame logic is held in reset while select is high
  assign linkRstN = nrst && !link.bus_select_n; // see RULE20 see RULE5

  // Address as it stands once the current bit is in
  assign addrFull = (l.bitCnt == 5'(shrp_pkg::ADDR_BITS - 1)) ?
    {l.addr[6:0], link.cmdData} : l.addr;

  // Reply drives only during data bytes of a read frame
  assign readPhase = (l.bitCnt >= 5'(shrp_pkg::ADDR_BITS)) && !l.done &&
    shrp_pkg::shrpIsRead(l.addr); // see RULE11 see RULE2

  // Link next-state: shift on each rising serial clock edge
  always_comb begin
    next_l = l;
    next_p = p;
    if (!l.done) begin
      next_l.bitCnt = l.bitCnt + 5'h1;
      if (l.bitCnt < 5'(shrp_pkg::ADDR_BITS)) begin
        next_l.addr = {l.addr[6:0], link.cmdData}; // see RULE3 see RULE7 see RULE1
      end else begin
        next_l.inShift = {l.inShift[14:0], link.cmdData}; // see RULE7
        next_l.outShift = {l.outShift[14:0], 1'b0};
      end
      if (l.bitCnt == 5'(shrp_pkg::ADDR_BITS - 1)) begin
        next_l.outShift = c.statusHold; // see RULE2
      end
      // Frame length comes from the address byte alone
      if (l.bitCnt == shrp_pkg::shrpFrameBits(addrFull) - 5'h1) begin // see RULE6 see RULE9
        next_l.done = 1'b1; // see RULE10
        if (shrp_pkg::shrpIsRead(addrFull)) begin
          next_p.rdTog = !p.rdTog;
        end else begin
          next_p.wrTog = !p.wrTog;
          next_p.wrAddr = addrFull;
          next_p.wrData = {l.inShift[14:0], link.cmdData};
        end
      end
    end
  end

  // Frame registers; gaps of any length just hold state
  always_ff @(posedge link.sclk or negedge linkRstN) begin // see RULE13 see RULE12
    if (!linkRstN) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  // Hand-over registers survive select release
  always_ff @(posedge link.sclk or negedge nrst) begin
    if (!nrst) begin
      p <= '0;
    end else begin
      p <= next_p;
    end
  end

  // Reply changes on the falling edge so it is stable while high
  always_ff @(negedge link.sclk or negedge linkRstN) begin // see RULE4 see RULE20
    if (!linkRstN) begin
      replyBit <= 1'b0;
      replyEn <= 1'b0;
    end else begin
      replyBit <= l.outShift[15];
      replyEn <= readPhase;
    end
  end

  assign link.replyData = replyBit;
  assign link.replyOe = replyEn; // see RULE11
  assign link.irqOut = 1'b0;
  assign link.irqOe = c.irqPend;

  // Core next-state: command execution, status and interrupt
  always_comb begin
    logic wrEvt;
    logic rdEvt;
    wrEvt = 1'b0;
    rdEvt = 1'b0;
    next_c = c;
    next_c.wrSync = {c.wrSync[1:0], p.wrTog};
    next_c.rdSync = {c.rdSync[1:0], p.rdTog};
    next_c.selSync = {c.selSync[1:0], link.bus_select_n};
    next_c.progWrStb = 1'b0;
    next_c.regWrStb = 1'b0;
    // A toggle counts once the second and third stages agree
    if (c.wrSync[2] == c.wrSync[1] && c.wrSync[2] != c.wrAcc) begin
      wrEvt = 1'b1;
      next_c.wrAcc = c.wrSync[2];
    end
    if (c.rdSync[2] == c.rdSync[1] && c.rdSync[2] != c.rdAcc) begin
      rdEvt = 1'b1;
      next_c.rdAcc = c.rdSync[2];
    end
    if (c.progTimer != 8'h00) begin
      next_c.progTimer = c.progTimer - 8'h01;
    end
    // A status read clears only the events it reported; later ones stay pending
    if (rdEvt) begin
      next_c.sticky = c.sticky & ~c.statusHold[shrp_pkg::STAT_EVT_LSB +: EVT_W]; // see RULE14
    end
    // Written commands take effect a few cycles after the frame
    if (wrEvt) begin // see RULE8
      unique case (p.wrAddr)
        shrp_pkg::ADDR_RESET: begin
          next_c.mode = shrp_pkg::SHRP_IDLE; // see RULE9 see RULE16
          next_c.powerDown = shrp_pkg::POWER_RESET;
          next_c.irqMask = '0;
          next_c.sticky = '0;
          next_c.progTimer = 8'h00;
        end
        shrp_pkg::ADDR_POWER: next_c.powerDown = p.wrData;
        shrp_pkg::ADDR_MODE: begin
          unique case (p.wrData[1:0])
            shrp_pkg::MODE_CODE_RX: next_c.mode = shrp_pkg::SHRP_RX; // see RULE15
            shrp_pkg::MODE_CODE_TX: next_c.mode = shrp_pkg::SHRP_TX;
            default: next_c.mode = shrp_pkg::SHRP_IDLE;
          endcase
        end
        shrp_pkg::ADDR_PROG: begin
          if (c.mode == shrp_pkg::SHRP_IDLE) begin // see RULE17
            next_c.progWrStb = 1'b1;
            next_c.progData = p.wrData;
            next_c.progTimer = PROG_BUSY_LD;
          end
        end
        shrp_pkg::ADDR_MASK: begin
          next_c.irqMask = p.wrData[shrp_pkg::STAT_EVT_LSB +: EVT_W];
        end
        default: begin
          next_c.regWrStb = 1'b1;
          next_c.regWrAddr = p.wrAddr;
          next_c.regWrData = p.wrData;
        end
      endcase
    end
    // New events set after any clear, so none is lost
    next_c.sticky = next_c.sticky | statusEvents;
    // Read word refreshes only while no frame can sample it
    if (c.selSync[2] && c.selSync[1]) begin
      next_c.statusHold = '0;
      next_c.statusHold[shrp_pkg::STAT_EVT_LSB +: EVT_W] = c.sticky;
      next_c.statusHold[shrp_pkg::STAT_READY_BIT] = (c.progTimer == 8'h00);
    end
    next_c.irqPend = |(next_c.sticky & next_c.irqMask); // see RULE14
  end

  // Core registers; power-on leaves the device idle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      c <= '0; // see RULE16
      c.selSync <= 3'h7;
      c.mode <= shrp_pkg::SHRP_IDLE;
      c.powerDown <= shrp_pkg::POWER_RESET;
    end else begin
      c <= next_c;
    end
  end

  // User-side outputs straight from registers
  assign mode = c.mode;
  assign powerDown = c.powerDown;
  assign progWrStb = c.progWrStb;
  assign progData = c.progData;
  assign regWrStb = c.regWrStb;
  assign regWrAddr = c.regWrAddr;
  assign regWrData = c.regWrData;
endmodule // shrp_device

//--- src/shrp_host.sv
`timescale 1ns/1ps
// Host end: makes the serial clock and runs one frame per request, preceded by status polls for ADDR_PROG
module shrp_host #(
  parameter int HALF_CYC = shrp_pkg::SCLK_HALF_CYC,
  parameter int LATENCY_CYC = shrp_pkg::WRITE_LATENCY_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  shrp_if.host link,
  input wire logic start,
  input wire logic [7:0] reqAddr,
  input wire logic [15:0] reqData,
  output logic busy,
  output logic doneStb,
  output logic [15:0] rdData,
  output logic irqPending
);
  if (HALF_CYC < 1 || HALF_CYC > 65535 || LATENCY_CYC < 1 || LATENCY_CYC > 65535) begin : gBad
    $error("HALF_CYC and LATENCY_CYC must be 1 to 65535");
  end

  localparam logic [15:0] HALF_LD = 16'(HALF_CYC - 1);
  localparam logic [15:0] LAT_LD = 16'(LATENCY_CYC - 1);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_SEL = 3'b001,
    H_LOW = 3'b011,
    H_HIGH = 3'b010,
    H_DONE = 3'b110,
    H_GAP = 3'b111,
    H_WAIT = 3'b100
  } shrp_hstate_e;

  typedef struct packed {
    shrp_hstate_e state;
    logic [15:0] tim;
    logic [4:0] bitCnt;
    logic [4:0] total;
    logic [23:0] tx;
    logic [15:0] rx;
    logic isRead;
    logic poll;
    logic again;
    logic [7:0] addr;
    logic [15:0] data;
    logic sclk;
    logic sel;
    logic cmd;
    logic cmdOe;
    logic done;
    logic [15:0] rdOut;
    logic [2:0] irqSync;
    logic irqAcc;
  } shrp_host_s;

  shrp_host_s c;
  shrp_host_s next_c;

  // Host next-state
  always_comb begin
    logic [7:0] curAddr;
    curAddr = c.poll ? shrp_pkg::ADDR_STATUS : c.addr;
    next_c = c;
    next_c.done = 1'b0;
    next_c.irqSync = {c.irqSync[1:0], !link.irqN};
    if (c.irqSync[2] == c.irqSync[1]) begin
      next_c.irqAcc = c.irqSync[2];
    end
    if (c.tim != 16'h0000) begin
      next_c.tim = c.tim - 16'h0001;
    end else begin
      unique case (c.state)
        H_IDLE: begin
          if (start) begin
            next_c.addr = reqAddr;
            next_c.data = reqData;
            next_c.poll = (reqAddr == shrp_pkg::ADDR_PROG); // see RULE19
            next_c.sel = 1'b0; // see RULE5
            next_c.tim = HALF_LD;
            next_c.state = H_SEL;
          end
        end
        H_SEL: begin
          next_c.isRead = shrp_pkg::shrpIsRead(curAddr); // see RULE2
          next_c.total = shrp_pkg::shrpFrameBits(curAddr); // see RULE6
          next_c.tx = (shrp_pkg::shrpDataBytes(curAddr) == 2'h1) ?
            {curAddr, c.data[7:0], 8'h00} : {curAddr, c.data}; // see RULE10 see RULE7
          next_c.bitCnt = 5'h00;
          next_c.cmd = curAddr[7]; // see RULE1
          next_c.cmdOe = 1'b1;
          next_c.tim = HALF_LD;
          next_c.state = H_LOW;
        end
        H_LOW: begin
          next_c.sclk = 1'b1;
          next_c.tim = HALF_LD;
          next_c.state = H_HIGH;
        end
        H_HIGH: begin
          next_c.sclk = 1'b0;
          if (c.isRead && c.bitCnt >= 5'(shrp_pkg::ADDR_BITS)) begin
            next_c.rx = {c.rx[14:0], link.replyData}; // see RULE4
          end
          next_c.tx = {c.tx[22:0], 1'b0};
          next_c.bitCnt = c.bitCnt + 5'h01;
          next_c.tim = HALF_LD;
          if (c.bitCnt == c.total - 5'h01) begin
            next_c.cmdOe = 1'b0;
            next_c.state = H_DONE;
          end else begin
            next_c.cmd = c.tx[22];
            next_c.cmdOe = (c.bitCnt < 5'(shrp_pkg::ADDR_BITS - 1)) || !c.isRead; // see RULE11
            next_c.state = H_LOW;
          end
        end
        H_DONE: begin
          next_c.sel = 1'b1; // see RULE5
          next_c.tim = HALF_LD;
          next_c.again = c.poll;
          if (c.poll) begin
            next_c.poll = !c.rx[shrp_pkg::STAT_READY_BIT]; // see RULE19
            next_c.state = H_GAP;
          end else begin
            next_c.done = 1'b1;
            next_c.rdOut = c.rx;
            if (c.isRead) begin
              next_c.state = H_GAP;
            end else begin
              next_c.tim = LAT_LD; // see RULE8
              next_c.state = H_WAIT;
            end
          end
        end
        H_GAP: begin
          next_c.state = c.again ? H_SEL : H_IDLE;
          next_c.sel = !c.again;
          next_c.tim = c.again ? HALF_LD : 16'h0000;
          next_c.again = 1'b0;
        end
        H_WAIT: next_c.state = H_IDLE;
        default: next_c.state = H_IDLE;
      endcase
    end
  end

  // Host registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      c <= '0;
      c.sel <= 1'b1;
      c.state <= H_IDLE;
    end else begin
      c <= next_c;
    end
  end

  // Link and user outputs
  assign link.sclk = c.sclk;
  assign link.bus_select_n = c.sel;
  assign link.cmdData = c.cmd;
  assign link.cmdOe = c.cmdOe;
  assign busy = (c.state != H_IDLE);
  assign doneStb = c.done;
  assign rdData = c.rdOut;
  assign irqPending = c.irqAcc;
endmodule // shrp_host

//--- verification/shrp_properties.sv
`timescale 1ns/1ps
// Watches the serial link between host and device ends
module shrp_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic bus_select_n,
  input wire logic cmdData,
  input wire logic cmdOe,
  input wire logic replyData,
  input wire logic replyOe,
  input wire logic irqOut,
  input wire logic irqOe,
  input wire logic irqN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic sclkQ;
  logic [5:0] rises;

  // Counts serial clock rises inside the current frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclkQ <= 1'b0;
      rises <= 6'h00;
    end else begin
      sclkQ <= sclk;
      if (bus_select_n) rises <= 6'h00;
      else if (sclk && !sclkQ) rises <= rises + 6'h01;
    end
  end

  property p_noOverlap;
    !(cmdOe && replyOe);
  endproperty
  a_noOverlap: assert property (p_noOverlap) else $error("both data lines driven");

  property p_replyIdle;
    bus_select_n && $past(bus_select_n) |-> !replyOe;
  endproperty
  a_replyIdle: assert property (p_replyIdle) else $error("reply driven while idle");

  property p_replyHold;
    sclk && $past(sclk) && replyOe && $past(replyOe) |-> $stable(replyData);
  endproperty
  a_replyHold: assert property (p_replyHold) else $error("reply moved while clock high");

  property p_cmdHold;
    sclk && $past(sclk) && cmdOe && $past(cmdOe) |-> $stable(cmdData);
  endproperty
  a_cmdHold: assert property (p_cmdHold) else $error("command moved while clock high");

  property p_selectGap;
    $rose(bus_select_n) |-> bus_select_n [*5];
  endproperty
  a_selectGap: assert property (p_selectGap) else $error("select gap too short");

  property p_frameLen;
    $rose(bus_select_n) |-> rises inside {6'd8, 6'd16, 6'd24};
  endproperty
  a_frameLen: assert property (p_frameLen) else $error("frame not whole bytes");

  property p_replyStart;
    $rose(replyOe) |-> rises == 6'd8;
  endproperty
  a_replyStart: assert property (p_replyStart) else $error("reply not after address");

  property p_irqLine;
    irqOe |-> !irqN && !irqOut;
  endproperty
  a_irqLine: assert property (p_irqLine) else $error("interrupt line not pulled low");

  // Main scenarios reached
  c_write: cover property ($rose(bus_select_n) && rises == 6'd24);
  c_cmd: cover property ($rose(bus_select_n) && rises == 6'd8);
  c_read: cover property ($rose(replyOe));
  c_irq: cover property ($rose(irqOe));
endmodule // shrp_properties

//--- verification/serial_host_register_port_tb.sv
`timescale 1ns/1ps
// Host end and device end face each other across one link
module serial_host_register_port_tb;
  typedef struct packed {
    logic [7:0] a;
    logic [15:0] d;
    logic [15:0] e;
  } shrp_row_s;

  logic clk, nrst, start, busy, doneStb, irqPending, progWrStb, regWrStb;
  logic [7:0] reqAddr, regWrAddr;
  logic [15:0] reqData, rdData, powerDown, progData, regWrData;
  logic [1:0] mode;
  logic [14:0] statusEvents;
  int nMismatch = 0, totalChecks = 0, nReg = 0, nProg = 0, expReg = 0, i = 0;
  shrp_row_s rows [8] = '{
    '{8'hc0, 16'ha5c3, 16'ha5c3}, '{8'hc1, 16'h0001, {14'h0, shrp_pkg::SHRP_RX}},
    '{8'hc1, 16'h0002, {14'h0, shrp_pkg::SHRP_TX}}, '{8'hc1, 16'h0003, 16'h0000},
    '{8'hc2, 16'h1234, 16'h1234}, '{8'h55, 16'h00b7, 16'h00b7},
    '{8'hcb, 16'hbeef, 16'hbeef}, '{8'hcd, 16'h0f0f, 16'h0f0f}};

  shrp_if link();
  shrp_host #(.HALF_CYC(5), .LATENCY_CYC(20)) shrp_host_inst (.clk(clk), .nrst(nrst),
    .link(link), .start(start), .reqAddr(reqAddr), .reqData(reqData), .busy(busy),
    .doneStb(doneStb), .rdData(rdData), .irqPending(irqPending));
  shrp_device shrp_device_inst (.clk(clk), .nrst(nrst), .link(link), .mode(mode),
    .powerDown(powerDown), .progWrStb(progWrStb), .progData(progData), .regWrStb(regWrStb),
    .regWrAddr(regWrAddr), .regWrData(regWrData), .statusEvents(statusEvents));
  shrp_properties shrp_properties_inst (.clk(clk), .nrst(nrst), .sclk(link.sclk),
    .bus_select_n(link.bus_select_n), .cmdData(link.cmdData), .cmdOe(link.cmdOe),
    .replyData(link.replyData), .replyOe(link.replyOe), .irqOut(link.irqOut),
    .irqOe(link.irqOe), .irqN(link.irqN));

  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Counts device write strobes
  always @(posedge clk) begin
    if (regWrStb === 1'b1) nReg++;
    if (progWrStb === 1'b1) nProg++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic waitIdle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge clk); #1;
      k++;
    end
    check({15'h0, busy}, 16'h0000);
  endtask

  // One whole frame through the host end
  task automatic xfer(input logic [7:0] a, input logic [15:0] d);
    int k;
    waitIdle();
    start = 1'b1;
    reqAddr = a;
    reqData = d;
    @(posedge clk); #1;
    start = 1'b0;
    k = 0;
    while (doneStb !== 1'b1 && k < 2000) begin
      @(posedge clk); #1;
      k++;
    end
    check({15'h0, doneStb}, 16'h0001);
    waitIdle();
  endtask

  task automatic pulseEvent();
    statusEvents = 15'h0001;
    @(posedge clk); #1;
    statusEvents = 15'h0000;
    repeat (12) @(posedge clk);
    #1;
  endtask

  task automatic testDone();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog cuts a hang short
  initial begin
    #400000;
    nMismatch++;
    testDone();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    start = 1'b0;
    reqAddr = 8'h00;
    reqData = 16'h0000;
    statusEvents = 15'h0000;
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check({14'h0, mode}, {14'h0, shrp_pkg::SHRP_IDLE});
    check(powerDown, shrp_pkg::POWER_RESET);
    xfer(shrp_pkg::ADDR_STATUS, 16'h0000);
    check(rdData, 16'h0001);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      xfer(rows[i].a, rows[i].d);
      if (rows[i].a == shrp_pkg::ADDR_POWER) check(powerDown, rows[i].e);
      else if (rows[i].a == shrp_pkg::ADDR_MODE) check({14'h0, mode}, rows[i].e);
      else begin
        expReg++;
        check(regWrData, rows[i].e);
        check({8'h0, regWrAddr}, {8'h0, rows[i].a});
        check(16'(nReg), 16'(expReg));
      end
    end
    $display("test table done");
    xfer(shrp_pkg::ADDR_MODE, 16'h0002);
    xfer(shrp_pkg::ADDR_PROG, 16'h1111);
    check(16'(nProg), 16'h0000);
    xfer(shrp_pkg::ADDR_MODE, 16'h0000);
    for (i = 0; i < 4 && rdData[0] !== 1'b1; i++) xfer(shrp_pkg::ADDR_STATUS, 16'h0000);
    check({15'h0, rdData[0]}, 16'h0001);
    xfer(shrp_pkg::ADDR_PROG, 16'h1357);
    check(16'(nProg), 16'h0001);
    check(progData, 16'h1357);
    $display("test program done");
    xfer(shrp_pkg::ADDR_MASK, 16'h0000);
    pulseEvent();
    check({15'h0, irqPending}, 16'h0000);
    xfer(shrp_pkg::ADDR_STATUS, 16'h0000);
    check(rdData, 16'h0003);
    repeat (10) @(posedge clk);
    #1;
    xfer(shrp_pkg::ADDR_STATUS, 16'h0000);
    check(rdData, 16'h0001);
    xfer(shrp_pkg::ADDR_MASK, 16'h0002);
    pulseEvent();
    check({15'h0, irqPending}, 16'h0001);
    xfer(shrp_pkg::ADDR_STATUS, 16'h0000);
    repeat (12) @(posedge clk);
    #1;
    check({15'h0, irqPending}, 16'h0000);
    $display("test interrupt done");
    xfer(shrp_pkg::ADDR_POWER, 16'hffff);
    xfer(shrp_pkg::ADDR_MODE, 16'h0001);
    xfer(shrp_pkg::ADDR_RESET, 16'h0000);
    check({14'h0, mode}, {14'h0, shrp_pkg::SHRP_IDLE});
    check(powerDown, shrp_pkg::POWER_RESET);
    $display("test reset command done");
    xfer(shrp_pkg::ADDR_MODE, 16'h0002);
    nrst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({14'h0, mode}, {14'h0, shrp_pkg::SHRP_IDLE});
    nrst = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    xfer(shrp_pkg::ADDR_AUDIO, 16'h4321);
    check(regWrData, 16'h4321);
    $display("test second reset done");
    testDone();
  end
endmodule // serial_host_register_port_tb
